// *** rtl/pbcr_pkg.sv ***
// Summary of operation
// - Self-clearing bits read one while their event lasts, then clear themselves.
// - Clear-on-read fields ignore writes; a read returns the value, then zeroes it, keeping an event in the read cycle.
// - Latched-low status drops to zero on its event and holds until read.
// - Latched-high status rises to one on its event and holds until read.
// - Permanent read-only fields always return their fixed value; writes do nothing.
// - Writing one to bit 15 starts soft reset; reads one until done; default zero.
// - Soft reset reloads strap configuration exactly like hardware reset.
// - Bit 14 loops MII transmit data onto receive outputs; zero is normal; default zero.
// - With autonegotiation off, bit 13 picks 100 Mb/s (one) or 10 Mb/s (zero).
// - Autonegotiation enable bit 12 loads from its strap at reset, stays writable.
// - Autonegotiation on ignores bits 8 and 13; off, they fix duplex and speed.
// - Bit 11 powers down the PHY; only registers keep working; default zero.
package pbcr_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STAT   = 8'h04;
    localparam logic [7:0] OFS_ECNT   = 8'h08;

    // Control register bit positions
    localparam int B_RESET    = 15;
    localparam int B_LOOP     = 14;
    localparam int B_SPEED    = 13;
    localparam int B_AN_EN    = 12;
    localparam int B_PDOWN    = 11;
    localparam int B_ISO      = 10;
    localparam int B_AN_RST   = 9;
    localparam int B_DUPLEX   = 8;
    localparam int B_COLT     = 7;

    // Status register layout
    localparam int S_LINK     = 0;
    localparam int S_FAULT    = 1;
    localparam int S_BUSY     = 2;
    localparam int S_PERM_LSB = 12;
    localparam logic [3:0]  PERM_ABILITY = 4'h6;

    // Reset values of the control fields not taken from straps
    localparam logic        CTRL_BIT_RST = 1'h0;

    // Error event counter width
    localparam int          CNT_W   = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

    // Soft reset duration, rounded up to whole clock cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int SW_RST_NS     = 1000;
    localparam int SW_RST_CYC    = (SW_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SW_RST_LOAD = 8'(SW_RST_CYC - 1);

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } pbcr_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } pbcr_wb_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] data;
    } pbcr_mii_t;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
    } pbcr_mode_t;

    typedef struct packed {
        logic speed_100;
        logic an_en;
        logic full_duplex;
    } pbcr_strap_t;

endpackage

// *** rtl/pbcr_latch.sv ***
`timescale 1ns/1ns
// Status bit that latches its event and holds it until management reads it
module pbcr_latch #(
    parameter bit HOLD_HIGH = 1'b1
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic cond,
    input  wire logic rd,
    output logic      q
);

    // Read reloads the live condition, so an event in the read cycle is kept
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= 1'b0;
        end else if (clk_en) begin
            if (rd) begin
                q <= cond;
            end else if (HOLD_HIGH) begin
                q <= q | cond;
            end else begin
                q <= q & cond;
            end
        end
    end

endmodule

// *** rtl/pbcr_swrst.sv ***
`timescale 1ns/1ns
// Soft reset sequencer: busy for a fixed number of cycles after a start
module pbcr_swrst (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    logic [7:0] cnt_q;

    // Last busy cycle; the strap reload happens on this edge
    assign done = busy && (cnt_q == 8'h00);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy  <= 1'b0;
            cnt_q <= 8'h00;
        end else if (clk_en) begin
            if (!busy && start) begin
                busy  <= 1'b1;
                cnt_q <= pbcr_pkg::SW_RST_LOAD;
            end else if (done) begin
                busy  <= 1'b0;
            end else if (busy) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end

endmodule

// *** rtl/pbcr_top.sv ***
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
// Basic mode control register bank with Wishbone classic slave
module pbcr_top (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    input  wire pbcr_pkg::pbcr_wb_req_t wb_req,
    output pbcr_pkg::pbcr_wb_rsp_t     wb_rsp,
    input  wire pbcr_pkg::pbcr_strap_t strap,
    input  wire logic                  link_ok,
    input  wire logic                  fault_evt,
    input  wire logic                  err_evt,
    input  wire logic                  an_started,
    input  wire pbcr_pkg::pbcr_mode_t  an_mode,
    input  wire pbcr_pkg::pbcr_mii_t   mii_tx,
    input  wire pbcr_pkg::pbcr_mii_t   phy_rx,
    output pbcr_pkg::pbcr_mii_t        mii_rx,
    output pbcr_pkg::pbcr_mode_t       mode,
    output logic                       an_enable,
    output logic                       an_restart,
    output logic                       power_down,
    output logic                       isolate,
    output logic                       col_test,
    output logic                       core_reset
);

    logic                         ack_q;
    logic [31:0]                  rdat_q;
    logic [31:0]                  rdat_d;
    logic                         acc;
    logic                         wr_ctrl;
    logic                         wr_hi;
    logic                         wr_lo;
    logic                         rd_stat;
    logic                         rd_ecnt;
    logic                         init_q;
    logic                         reload;
    logic                         rst_start;
    logic                         rst_busy;
    logic                         rst_done;
    logic                         loop_q;
    logic                         speed_q;
    logic                         an_en_q;
    logic                         pdown_q;
    logic                         iso_q;
    logic                         an_rst_q;
    logic                         duplex_q;
    logic                         colt_q;
    logic                         link_ll;
    logic                         fault_lh;
    logic [pbcr_pkg::CNT_W-1:0]   ecnt_q;
    logic [15:0]                  ctrl_word;
    logic [15:0]                  stat_word;
    pbcr_pkg::pbcr_mode_t         mode_q;
    pbcr_pkg::pbcr_mii_t          rx_q;

    // Bus decode: a request is taken on the edge before ack rises
    assign acc     = wb_req.cyc && wb_req.stb && !ack_q;
    assign wr_ctrl = acc && wb_req.we && (wb_req.adr == pbcr_pkg::OFS_CTRL) && !rst_busy;
    assign wr_hi   = wr_ctrl && wb_req.sel[1];
    assign wr_lo   = wr_ctrl && wb_req.sel[0];
    assign rd_stat = acc && !wb_req.we && (wb_req.adr == pbcr_pkg::OFS_STAT);
    assign rd_ecnt = acc && !wb_req.we && (wb_req.adr == pbcr_pkg::OFS_ECNT);

    // a one in bit 15 starts reset
    assign rst_start = wr_hi && wb_req.dat[pbcr_pkg::B_RESET];
    assign reload    = init_q || rst_done;

    pbcr_swrst u_swrst (
        .clock  (clock),
        .rst    (rst),
        .clk_en (clk_en),
        .start  (rst_start),
        .busy   (rst_busy),
        .done   (rst_done)
    );

    // Straps are caught on the first enabled edge after hardware reset release
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            init_q <= 1'b1;
        end else if (clk_en) begin
            init_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loop_q   <= 1'b0;
            speed_q  <= 1'b0;
            an_en_q  <= 1'b0;
            pdown_q  <= 1'b0;
            iso_q    <= 1'b0;
            duplex_q <= 1'b0;
            colt_q   <= 1'b0;
        end else if (clk_en) begin
            if (reload) begin
                loop_q   <= 1'b0;
                speed_q  <= strap.speed_100;
                an_en_q  <= strap.an_en;
                pdown_q  <= 1'b0;
                iso_q    <= 1'b0;
                duplex_q <= strap.full_duplex;
                colt_q   <= 1'b0;
            end else begin
                if (wr_hi) begin
                    loop_q   <= wb_req.dat[pbcr_pkg::B_LOOP];
                    speed_q  <= wb_req.dat[pbcr_pkg::B_SPEED];
                    an_en_q  <= wb_req.dat[pbcr_pkg::B_AN_EN];
                    pdown_q  <= wb_req.dat[pbcr_pkg::B_PDOWN];
                    iso_q    <= wb_req.dat[pbcr_pkg::B_ISO];
                    duplex_q <= wb_req.dat[pbcr_pkg::B_DUPLEX];
                end
                if (wr_lo) begin
                    colt_q <= wb_req.dat[pbcr_pkg::B_COLT];
                end
            end
        end
    end

    // restart bit clears once negotiation starts
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            an_rst_q <= 1'b0;
        end else if (clk_en) begin
            if (reload) begin
                an_rst_q <= 1'b0;
            end else if (wr_hi && wb_req.dat[pbcr_pkg::B_AN_RST] && an_en_q) begin
                an_rst_q <= 1'b1; // A fresh request beats the clearing event
            end else if (an_started) begin
                an_rst_q <= 1'b0;
            end
        end
    end

    // negotiated result overrides bits 8 and 13
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_q <= '0;
        end else if (clk_en) begin
            if (an_en_q) begin
                mode_q <= an_mode;
            end else begin
                mode_q.speed_100   <= speed_q;
                mode_q.full_duplex <= duplex_q;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_q <= '0;
        end else if (clk_en) begin
            if (pdown_q || iso_q || rst_busy) begin
                rx_q <= '0;
            end else if (loop_q) begin
                rx_q <= mii_tx;
            end else begin
                rx_q <= phy_rx;
            end
        end
    end

    pbcr_latch #(
        .HOLD_HIGH (1'b0)
    ) u_link_ll (
        .clock  (clock),
        .rst    (rst),
        .clk_en (clk_en),
        .cond   (link_ok),
        .rd     (rd_stat),
        .q      (link_ll)
    );

    pbcr_latch #(
        .HOLD_HIGH (1'b1)
    ) u_fault_lh (
        .clock  (clock),
        .rst    (rst),
        .clk_en (clk_en),
        .cond   (fault_evt),
        .rd     (rd_stat),
        .q      (fault_lh)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ecnt_q <= '0;
        end else if (clk_en) begin
            if (rd_ecnt) begin
                ecnt_q <= {{(pbcr_pkg::CNT_W-1){1'b0}}, err_evt}; // Event in read cycle kept
            end else if (err_evt && ecnt_q != pbcr_pkg::CNT_MAX) begin
                ecnt_q <= ecnt_q + 8'h01; // Saturates rather than wrapping
            end
        end
    end

    // Register images as software sees them; low control bits stay zero
    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[pbcr_pkg::B_RESET]  = rst_busy;
        ctrl_word[pbcr_pkg::B_LOOP]   = loop_q;
        ctrl_word[pbcr_pkg::B_SPEED]  = speed_q;
        ctrl_word[pbcr_pkg::B_AN_EN]  = an_en_q;
        ctrl_word[pbcr_pkg::B_PDOWN]  = pdown_q;
        ctrl_word[pbcr_pkg::B_ISO]    = iso_q;
        ctrl_word[pbcr_pkg::B_AN_RST] = an_rst_q;
        ctrl_word[pbcr_pkg::B_DUPLEX] = duplex_q;
        ctrl_word[pbcr_pkg::B_COLT]   = colt_q;
        stat_word = 16'h0000;
        stat_word[pbcr_pkg::S_LINK]   = link_ll;
        stat_word[pbcr_pkg::S_FAULT]  = fault_lh;
        stat_word[pbcr_pkg::S_BUSY]   = rst_busy;
        stat_word[pbcr_pkg::S_PERM_LSB +: 4] = pbcr_pkg::PERM_ABILITY;
    end

    // Read mux; unmapped offsets read zero and are still acknowledged
    always_comb begin
        rdat_d = 32'h0000_0000;
        if (wb_req.adr == pbcr_pkg::OFS_CTRL) begin
            rdat_d[15:0] = ctrl_word;
        end else if (wb_req.adr == pbcr_pkg::OFS_STAT) begin
            rdat_d[15:0] = stat_word;
        end else if (wb_req.adr == pbcr_pkg::OFS_ECNT) begin
            rdat_d[pbcr_pkg::CNT_W-1:0] = ecnt_q;
        end
    end

    // One-cycle answer, dropped the cycle after it was given
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else if (clk_en) begin
            ack_q <= acc;
            if (acc && !wb_req.we) begin
                rdat_q <= rdat_d;
            end
        end
    end

    assign wb_rsp.ack = ack_q;
    assign wb_rsp.dat = rdat_q;
    assign mii_rx     = rx_q;
    assign mode       = mode_q;
    assign an_enable  = an_en_q;
    assign an_restart = an_rst_q;
    assign power_down = pdown_q;
    assign isolate    = iso_q;
    assign col_test   = colt_q;
    assign core_reset = rst_busy;

    // Checks on this bank, all in the one clock domain
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_reset_start: assert property (
        clk_en && rst_start |=> rst_busy && ctrl_word[pbcr_pkg::B_RESET]
    ) else $error("soft reset did not start");

    a_reset_hold: assert property (
        rst_busy && !rst_done |=> rst_busy
    ) else $error("soft reset ended early");

    a_restrap: assert property (
        clk_en && rst_done |=> an_en_q == $past(strap.an_en)
            && speed_q == $past(strap.speed_100) && !loop_q && !pdown_q
    ) else $error("soft reset did not reload straps");

    a_strap_init: assert property (
        clk_en && init_q |=> an_en_q == $past(strap.an_en) && !init_q
    ) else $error("enable not taken from strap");

    a_an_restart_sc: assert property (
        clk_en && an_rst_q && an_started && !wr_hi && !reload |=> !an_rst_q
    ) else $error("restart bit did not self clear");

    a_count_cor: assert property (
        clk_en && rd_ecnt && !err_evt |=> ecnt_q == '0 && wb_rsp.ack
    ) else $error("counter not cleared by read");

    a_link_ll: assert property (
        clk_en && !link_ok |=> !link_ll
    ) else $error("link drop not latched");

    a_fault_lh: assert property (
        clk_en && !rd_stat && fault_lh |=> fault_lh
    ) else $error("fault latch released without read");

    a_perm_field: assert property (
        clk_en && rd_stat |=> rdat_q[pbcr_pkg::S_PERM_LSB +: 4] == pbcr_pkg::PERM_ABILITY
    ) else $error("permanent field changed");

    a_loop_path: assert property (
        clk_en && loop_q && !pdown_q && !iso_q && !rst_busy |=> mii_rx == $past(mii_tx)
    ) else $error("loopback data mismatch");

    a_forced_speed: assert property (
        clk_en && !an_en_q |=> mode_q.speed_100 == $past(speed_q)
    ) else $error("forced speed not applied");

    a_an_override: assert property (
        clk_en && an_en_q |=> mode_q == $past(an_mode)
    ) else $error("negotiated mode not applied");

    a_power_quiet: assert property (
        clk_en && pdown_q && !wr_hi && !reload |=> !mii_rx.valid && power_down
    ) else $error("datapath active in power down");

endmodule

// *** verif/pbcr_mgmt.sv ***
`timescale 1ns/1ns
// Management station model: classic Wishbone single cycles plus MAC receive watch
module pbcr_mgmt #(
    parameter int DEAD_CYC = 5000
) (
    input  wire logic                   clock,
    output pbcr_pkg::pbcr_wb_req_t      wb_req,
    input  wire pbcr_pkg::pbcr_wb_rsp_t wb_rsp,
    input  wire pbcr_pkg::pbcr_mii_t    mii_rx,
    output logic                        timed_out
);
    // Idle bus from time zero so the slave never sees an unknown request
    initial begin
        wb_req    = '0;
        timed_out = 1'b0;
    end

    // Request held until ack is sampled high; only the bench watchdog ends a dead wait
    task automatic access(input logic we, input logic [7:0] adr,
                          input logic [15:0] wdat, output logic [15:0] rdat);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h3,
                    dat: {16'h0000, wdat}};
        do begin
            @(posedge clock);
        end while (wb_rsp.ack !== 1'b1);
        rdat = wb_rsp.dat[15:0];
        wb_req <= '0;
        @(posedge clock);
    endtask

    task automatic wait_rx(input pbcr_pkg::pbcr_mii_t exp);
        int n;
        n = 0;
        while (mii_rx !== exp && n < DEAD_CYC) begin
            @(posedge clock);
            n++;
        end
        // Data still absent after the whole dead time is a real failure
        if (n >= DEAD_CYC) timed_out = 1'b1;
    endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ns
// Self-checking bench for the basic mode control register bank
module tb;
    logic                   clock;
    logic                   rst;
    logic                   clk_en;
    logic                   link_ok;
    logic                   fault_evt;
    logic                   err_evt;
    logic                   an_started;
    logic                   tmo;
    logic                   an_enable;
    logic                   an_restart;
    logic                   power_down;
    logic                   isolate;
    logic                   col_test;
    logic                   core_reset;
    logic [15:0]            r;
    int                     n;
    int                     errors;
    int                     comparisons;
    pbcr_pkg::pbcr_wb_req_t wb_req;
    pbcr_pkg::pbcr_wb_rsp_t wb_rsp;
    pbcr_pkg::pbcr_strap_t  strap;
    pbcr_pkg::pbcr_mode_t   an_mode;
    pbcr_pkg::pbcr_mode_t   mode;
    pbcr_pkg::pbcr_mii_t    mii_tx;
    pbcr_pkg::pbcr_mii_t    phy_rx;
    pbcr_pkg::pbcr_mii_t    mii_rx;

    pbcr_top DUT (
        .clock(clock), .rst(rst), .clk_en(clk_en), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .strap(strap), .link_ok(link_ok), .fault_evt(fault_evt), .err_evt(err_evt),
        .an_started(an_started), .an_mode(an_mode), .mii_tx(mii_tx), .phy_rx(phy_rx),
        .mii_rx(mii_rx), .mode(mode), .an_enable(an_enable), .an_restart(an_restart),
        .power_down(power_down), .isolate(isolate), .col_test(col_test),
        .core_reset(core_reset)
    );

    pbcr_mgmt mgmt (
        .clock(clock), .wb_req(wb_req), .wb_rsp(wb_rsp), .mii_rx(mii_rx),
        .timed_out(tmo)
    );

    // Register values, masked to the bits under test
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: register read %h, expected %h", $time, got, exp);
        end
    endtask

    // Levels seen on output pins
    task automatic chk_out(input logic [4:0] got, input logic [4:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: output %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        mgmt.access(1'b0, a, 16'h0000, d);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] x;
        mgmt.access(1'b1, a, d, x);
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clock);
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Free-running 10 MHz clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Watchdog sized well past the loopback dead time plus all bus traffic
    initial begin
        step(20000);
        errors++;
        finish_test;
    end

    // Main sequence
    initial begin
        errors = 0;
        comparisons = 0;
        rst = 1'b1;
        clk_en = 1'b1;
        link_ok = 1'b1;
        fault_evt = 1'b0;
        err_evt = 1'b0;
        an_started = 1'b0;
        strap = 3'b101;
        an_mode = 2'b10;
        mii_tx = 5'h00;
        phy_rx = 5'h00;
        step(4);
        rst <= 1'b0;
        step(2);
        rd(pbcr_pkg::OFS_CTRL, r);
        chk_reg(r & 16'hFF80, 16'h2100);
        chk_out({3'b000, mode}, 5'h03);
        chk_out({4'h0, an_enable}, 5'h00);
        wr(pbcr_pkg::OFS_CTRL, 16'h0000);
        step(2);
        chk_out({3'b000, mode}, 5'h00);
        wr(pbcr_pkg::OFS_CTRL, 16'h3100);
        step(2);
        chk_out({3'b000, mode}, 5'h02);
        chk_out({4'h0, an_enable}, 5'h01);
        // Restart bit holds until negotiation reports it has started
        wr(pbcr_pkg::OFS_CTRL, 16'h1200);
        rd(pbcr_pkg::OFS_CTRL, r);
        chk_reg(r & 16'h0200, 16'h0200);
        chk_out({4'h0, an_restart}, 5'h01);
        an_started <= 1'b1;
        step(1);
        an_started <= 1'b0;
        step(2);
        rd(pbcr_pkg::OFS_CTRL, r);
        chk_reg(r & 16'h0200, 16'h0000);
        // Loopback against a distinct line nibble
        mii_tx <= 5'h1A;
        phy_rx <= 5'h15;
        wr(pbcr_pkg::OFS_CTRL, 16'h5000);
        mgmt.wait_rx(5'h1A);
        chk_out(mii_rx, 5'h1A);
        wr(pbcr_pkg::OFS_CTRL, 16'h1000);
        step(2);
        chk_out(mii_rx, 5'h15);
        wr(pbcr_pkg::OFS_CTRL, 16'h1800);
        step(1);
        chk_out({4'h0, power_down}, 5'h01);
        chk_out(mii_rx, 5'h00);
        rd(pbcr_pkg::OFS_CTRL, r);
        chk_reg(r & 16'h0800, 16'h0800);
        // Isolate and collision test drive their pins; isolate also silences receive
        wr(pbcr_pkg::OFS_CTRL, 16'h1480);
        step(1);
        chk_out({2'b00, isolate, col_test, power_down}, 5'h06);
        chk_out(mii_rx, 5'h00);
        // Soft reset with new straps; a zero written mid-reset must not end it
        strap <= 3'b010;
        wr(pbcr_pkg::OFS_CTRL, 16'hC000);
        chk_out({4'h0, core_reset}, 5'h01);
        rd(pbcr_pkg::OFS_CTRL, r);
        chk_reg(r & 16'h8000, 16'h8000);
        wr(pbcr_pkg::OFS_CTRL, 16'h0000);
        chk_out({4'h0, core_reset}, 5'h01);
        n = 0;
        while (core_reset !== 1'b0 && n < 40) begin
            step(1);
            n++;
        end
        step(2);
        rd(pbcr_pkg::OFS_CTRL, r);
        chk_reg(r & 16'hFF80, 16'h1000);
        chk_out({3'b000, mode}, 5'h02);
        // Latched status: clear stale latches, then pulse the events
        rd(pbcr_pkg::OFS_STAT, r);
        link_ok <= 1'b0;
        fault_evt <= 1'b1;
        step(1);
        link_ok <= 1'b1;
        fault_evt <= 1'b0;
        step(2);
        rd(pbcr_pkg::OFS_STAT, r);
        chk_reg(r & 16'h0003, 16'h0002);
        rd(pbcr_pkg::OFS_STAT, r);
        chk_reg(r & 16'h0003, 16'h0001);
        wr(pbcr_pkg::OFS_STAT, 16'h0000);
        rd(pbcr_pkg::OFS_STAT, r);
        chk_reg(r & 16'hF000, {pbcr_pkg::PERM_ABILITY, 12'h000});
        // Error counter counts pulses, clears on read, ignores writes
        repeat (3) begin
            err_evt <= 1'b1;
            step(1);
            err_evt <= 1'b0;
            step(1);
        end
        rd(pbcr_pkg::OFS_ECNT, r);
        chk_reg(r & 16'h00FF, 16'h0003);
        wr(pbcr_pkg::OFS_ECNT, 16'h0055);
        rd(pbcr_pkg::OFS_ECNT, r);
        chk_reg(r & 16'h00FF, 16'h0000);
        rd(8'h0C, r);
        chk_reg(r, 16'h0000);
        chk_out({4'h0, tmo}, 5'h00);
        finish_test;
    end
endmodule
